// ### spi_eeprom_command_status.sv
// Functional notes
// - Bytes arrive MSB first, opcode first.
// - Unknown opcode ignores bus until deselect.
// - Opcode 06 sets the write enable latch.
// - Opcode 04 clears the write enable latch.
// - Opcode 05 streams status byte repeatedly.
// - Opcode 01 writes one status byte.
// - Opcodes 03/02 read/write array, two-byte address.
// - Opcodes 83/82 serve ID, lock, serial.
// - Address bits pick ID, lock, serial; opcodes 03/02 pick array.
// - Latch clears at reset, clear, write completion.
// - Status reads allowed during write cycle.
// - Busy bit shows active write cycle.
// - Latch low rejects array and status writes.
// - Protect bits change only by status write.
// - Disable bit plus low pin locks status.
// - Deselect starts cycle; bits update after it.
// - Busy during status cycle; latch cleared after.
// - Bits b6..b4 read zero, b1/b0 untouched.
// - Protect mode follows later event, pin leaves.
// - Sample input on rising, shift out falling.
// - Read address increments and wraps to zero.
// - Deselect ends read, output released.
// - Protect pair selects protected array range.
// - Execute only when deselected at byte boundary.
// - Array read ignored during write cycle.
// Purpose: Command decoder, status and protection logic of a serial EEPROM.
// Assumes: Array read data is valid the cycle after array_rd_req.
// Notes: Serial pins are sampled by sys_clk through two flip-flops.
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;
  assign in_ready = count != (PW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : byte_fifo

module spi_eeprom_command_status #(
  parameter int WRITE_CYCLES = 1000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic wp_n,
  output logic miso,
  output logic miso_oe,
  output logic [13:0] array_rd_addr,
  output logic array_rd_req,
  input wire logic [7:0] array_rd_data,
  output logic [13:0] array_wr_addr,
  output logic [7:0] array_wr_data,
  output logic array_wr_valid,
  input wire logic array_wr_ready,
  output logic [1:0] aux_region,
  output logic [7:0] status_register
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  function automatic logic prot_hit(input logic [1:0] bp, input logic [13:0] a);
    case (bp)
      2'h1: prot_hit = a >= eeprom_pkg::PROT_QUARTER;
      2'h2: prot_hit = a >= eeprom_pkg::PROT_HALF;
      2'h3: prot_hit = 1'b1;
      default: prot_hit = 1'b0;
    endcase
  endfunction : prot_hit

  function automatic eeprom_pkg::region_t region_of(input logic [15:0] a);
    if (a[eeprom_pkg::SEL_SERIAL]) begin
      region_of = eeprom_pkg::REG_SERIAL;
    end else if (a[eeprom_pkg::SEL_LOCK]) begin
      region_of = eeprom_pkg::REG_LOCK;
    end else begin
      region_of = eeprom_pkg::REG_ID;
    end
  endfunction : region_of

  logic sel_s1, sel_s2, sel_q;
  logic sck_s1, sck_s2, sck_q;
  logic mosi_s1, mosi_s2, wp_s1, wp_s2;
  eeprom_pkg::spi_state_t state;
  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic [7:0] opcode;
  logic [7:0] addr_hi;
  logic addr_cnt;
  logic [6:0] nbytes;
  logic overflow;
  logic write_enable_latch, busy;
  eeprom_pkg::write_kind_t kind;
  logic [31:0] cyc_cnt;
  logic status_write_disable;
  logic [1:0] bp;
  logic [2:0] pend;
  logic [7:0] out_shift;
  logic rd_pend;
  logic fifo_in_ready;
  logic fifo_out_valid;

  logic sck_rise, sck_fall, sel_fall, cs_rise, byte_done;
  logic [7:0] rx_byte;
  logic addr_done, boundary_ok, hw_protect_mode;
  logic exec_set, exec_clear, start_status, start_mem, start_aux;
  logic start_any, cycle_done, push, flush;

  // Every serial pin passes two flip-flops before any logic sees it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {sel_s1, sel_s2, sel_q} <= 3'h7;
      {sck_s1, sck_s2, sck_q} <= 3'h0;
      {mosi_s1, mosi_s2, wp_s1, wp_s2} <= 4'hf;
    end else begin
      {sel_s1, sel_s2, sel_q} <= {sel_n, sel_s1, sel_s2};
      {sck_s1, sck_s2, sck_q} <= {sck, sck_s1, sck_s2};
      {mosi_s1, mosi_s2, wp_s1, wp_s2} <= {mosi, mosi_s1, wp_n, wp_s1};
    end
  end

  assign sck_rise = sck_s2 && !sck_q && !sel_s2;
  assign sck_fall = !sck_s2 && sck_q && !sel_s2;
  assign sel_fall = sel_q && !sel_s2;
  assign cs_rise = sel_s2 && !sel_q;
  assign rx_byte = {shift_in, mosi_s2};
  assign byte_done = sck_rise && bit_cnt == eeprom_pkg::LAST_BIT &&
                     state != eeprom_pkg::ST_IDLE && state != eeprom_pkg::ST_WAIT;
  assign addr_done = byte_done && state == eeprom_pkg::ST_ADDR && addr_cnt;
  assign hw_protect_mode = status_write_disable && !wp_s2;
  assign status_register = {status_write_disable, eeprom_pkg::UNUSED_BITS, bp, write_enable_latch, busy};

  // Commands run only when select rises on a byte boundary.
  assign boundary_ok = cs_rise && bit_cnt == '0 && state == eeprom_pkg::ST_WDATA;
  assign exec_set = boundary_ok && opcode == eeprom_pkg::OP_LATCH_SET &&
                    nbytes == eeprom_pkg::NO_BYTES;
  assign exec_clear = boundary_ok && opcode == eeprom_pkg::OP_LATCH_CLEAR &&
                      nbytes == eeprom_pkg::NO_BYTES;
  assign start_status = boundary_ok && opcode == eeprom_pkg::OP_STATUS_WRITE &&
                        nbytes == eeprom_pkg::ONE_BYTE && write_enable_latch && !busy &&
                        !hw_protect_mode;
  assign start_mem = boundary_ok && opcode == eeprom_pkg::OP_ARRAY_WRITE &&
                     nbytes != eeprom_pkg::NO_BYTES && write_enable_latch && !busy && !overflow &&
                     !prot_hit(bp, array_wr_addr);
  assign start_aux = boundary_ok && opcode == eeprom_pkg::OP_AUX_WRITE &&
                     nbytes != eeprom_pkg::NO_BYTES && write_enable_latch && !busy;
  assign start_any = start_status || start_mem || start_aux;
  assign cycle_done = busy && cyc_cnt == '0;

  // Frame sequencer: opcode, address, data and read-out phases.
  always_ff @(posedge sys_clk) begin
    if (rst || sel_s2) begin
      state <= eeprom_pkg::ST_IDLE;
      bit_cnt <= '0;
      addr_cnt <= 1'b0;
      nbytes <= eeprom_pkg::NO_BYTES;
    end else if (sel_fall) begin
      state <= eeprom_pkg::ST_OPCODE;
      bit_cnt <= '0;
      addr_cnt <= 1'b0;
      nbytes <= eeprom_pkg::NO_BYTES;
    end else if (sck_rise && state != eeprom_pkg::ST_WAIT) begin
      bit_cnt <= bit_cnt + 1'b1;
      if (byte_done) begin
        case (state)
          eeprom_pkg::ST_OPCODE: begin
            case (rx_byte)
              eeprom_pkg::OP_LATCH_SET, eeprom_pkg::OP_LATCH_CLEAR,
              eeprom_pkg::OP_STATUS_WRITE: state <= eeprom_pkg::ST_WDATA;
              eeprom_pkg::OP_STATUS_READ: state <= eeprom_pkg::ST_RDOUT;
              eeprom_pkg::OP_ARRAY_READ, eeprom_pkg::OP_ARRAY_WRITE,
              eeprom_pkg::OP_AUX_READ, eeprom_pkg::OP_AUX_WRITE:
                state <= eeprom_pkg::ST_ADDR;
              default: state <= eeprom_pkg::ST_WAIT;
            endcase
          end
          eeprom_pkg::ST_ADDR: begin
            addr_cnt <= 1'b1;
            if (addr_cnt) begin
              if (opcode == eeprom_pkg::OP_ARRAY_WRITE || opcode == eeprom_pkg::OP_AUX_WRITE) begin
                state <= eeprom_pkg::ST_WDATA;
              end else if (busy) begin
                state <= eeprom_pkg::ST_WAIT;
              end else begin
                state <= eeprom_pkg::ST_RDOUT;
              end
            end
          end
          eeprom_pkg::ST_WDATA: begin
            if (nbytes != eeprom_pkg::MAX_BYTES) begin
              nbytes <= nbytes + 1'b1;
            end
          end
          eeprom_pkg::ST_RDOUT: state <= eeprom_pkg::ST_RDOUT;
          default: state <= eeprom_pkg::ST_WAIT;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_in <= '0;
      opcode <= '0;
      addr_hi <= '0;
      aux_region <= eeprom_pkg::REG_ARRAY;
      array_wr_addr <= '0;
    end else if (sck_rise) begin
      shift_in <= rx_byte[6:0];
      if (byte_done && state == eeprom_pkg::ST_OPCODE) begin
        opcode <= rx_byte;
      end
      if (byte_done && state == eeprom_pkg::ST_ADDR && !addr_cnt) begin
        addr_hi <= rx_byte;
      end
      if (addr_done) begin
        array_wr_addr <= {addr_hi[5:0], rx_byte};
        aux_region <= (opcode[7]) ? region_of({addr_hi, rx_byte}) : eeprom_pkg::REG_ARRAY;
      end
    end
  end

  // Write enable latch; a set arriving with a clear wins.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      write_enable_latch <= 1'b0;
    end else if (exec_set) begin
      write_enable_latch <= 1'b1;
    end else if (exec_clear || cycle_done) begin
      write_enable_latch <= 1'b0;
    end
  end

  // Self-timed write cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy <= 1'b0;
      cyc_cnt <= '0;
      kind <= eeprom_pkg::WK_STATUS;
    end else if (start_any) begin
      busy <= 1'b1;
      cyc_cnt <= 32'(WRITE_CYCLES - 1);
      kind <= start_status ? eeprom_pkg::WK_STATUS :
              start_mem ? eeprom_pkg::WK_ARRAY : eeprom_pkg::WK_AUX;
    end else if (busy) begin
      if (cycle_done) begin
        busy <= 1'b0;
      end else begin
        cyc_cnt <= cyc_cnt - 1'b1;
      end
    end
  end

  // Non-volatile bits take their new value only at the end of the cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {status_write_disable, bp} <= eeprom_pkg::NV_RESET;
      pend <= eeprom_pkg::NV_RESET;
    end else begin
      // Only a status write frame outside a cycle may stage new bits.
      if (byte_done && state == eeprom_pkg::ST_WDATA && !busy &&
          opcode == eeprom_pkg::OP_STATUS_WRITE) begin
        pend <= {rx_byte[eeprom_pkg::SB_DISABLE], rx_byte[eeprom_pkg::SB_PROT_HI],
                 rx_byte[eeprom_pkg::SB_PROT_LO]};
      end
      if (cycle_done && kind == eeprom_pkg::WK_STATUS) begin
        {status_write_disable, bp} <= pend;
      end
    end
  end

  // Array read address walks forward and wraps past the top.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      array_rd_addr <= '0;
      array_rd_req <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= array_rd_req;
      array_rd_req <= 1'b0;
      if (addr_done && opcode == eeprom_pkg::OP_ARRAY_READ && !busy) begin
        array_rd_addr <= {addr_hi[5:0], rx_byte};
        array_rd_req <= 1'b1;
      end else if (byte_done && state == eeprom_pkg::ST_RDOUT &&
                   opcode == eeprom_pkg::OP_ARRAY_READ) begin
        array_rd_addr <= array_rd_addr + 1'b1;
        array_rd_req <= 1'b1;
      end
    end
  end

  // Output shifter changes on the falling serial clock edge.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_shift <= '0;
      miso <= 1'b0;
    end else if (rd_pend) begin
      out_shift <= array_rd_data;
    end else if (byte_done && state == eeprom_pkg::ST_OPCODE) begin
      out_shift <= (rx_byte == eeprom_pkg::OP_STATUS_READ) ? status_register : 8'h00;
    end else if (byte_done && state == eeprom_pkg::ST_RDOUT &&
                 opcode == eeprom_pkg::OP_STATUS_READ) begin
      out_shift <= status_register;
    end else if (addr_done && opcode == eeprom_pkg::OP_AUX_READ) begin
      out_shift <= 8'h00;
    end else if (sck_fall && state == eeprom_pkg::ST_RDOUT) begin
      miso <= out_shift[7];
      out_shift <= {out_shift[6:0], 1'b0};
    end
  end

  assign miso_oe = !sel_s2 && state == eeprom_pkg::ST_RDOUT;

  // Write data bytes wait in the FIFO until the array cycle drains them.
  assign push = byte_done && state == eeprom_pkg::ST_WDATA &&
                opcode == eeprom_pkg::OP_ARRAY_WRITE && !busy;
  assign flush = (cs_rise && !start_mem) || cycle_done;
  assign array_wr_valid = fifo_out_valid && busy && kind == eeprom_pkg::WK_ARRAY;

  always_ff @(posedge sys_clk) begin
    if (rst || sel_fall) begin
      overflow <= 1'b0;
    end else if (push && !fifo_in_ready) begin
      overflow <= 1'b1;
    end
  end

  byte_fifo #(.WIDTH(eeprom_pkg::FIFO_WIDTH), .DEPTH(eeprom_pkg::FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst(rst),
    .flush(flush),
    .in_data(rx_byte),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(array_wr_data),
    .out_valid(fifo_out_valid),
    .out_ready(array_wr_ready && busy && kind == eeprom_pkg::WK_ARRAY)
  );

  property p_wel_set;
    exec_set |=> write_enable_latch ##1 write_enable_latch || $past(exec_clear) || $past(cycle_done);
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set");
  property p_wel_clear;
    exec_clear && !exec_set |=> !write_enable_latch;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared");
  property p_done_clears;
    cycle_done |=> !busy && (!write_enable_latch || $past(exec_set));
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("cycle end wrong");
  property p_no_wel;
    cs_rise && !write_enable_latch && !busy |=> !busy;
  endproperty
  a_no_wel: assert property (p_no_wel) else $error("write ran without latch");
  property p_nv_change;
    $changed({status_write_disable, bp}) |-> $past(cycle_done) && $past(kind) == eeprom_pkg::WK_STATUS;
  endproperty
  a_nv_change: assert property (p_nv_change) else $error("nv bits moved");
  property p_hw_reject;
    cs_rise && hw_protect_mode && !busy && opcode == eeprom_pkg::OP_STATUS_WRITE |=> !busy;
  endproperty
  a_hw_reject: assert property (p_hw_reject) else $error("protected write ran");
  property p_wait_hold;
    state == eeprom_pkg::ST_WAIT && !sel_s2 ##1 !sel_s2 |-> state == eeprom_pkg::ST_WAIT;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("left wait early");
  property p_busy_read;
    addr_done && opcode == eeprom_pkg::OP_ARRAY_READ && busy |=> state == eeprom_pkg::ST_WAIT
      && !array_rd_req;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("read during cycle");
  property p_read_inc;
    byte_done && state == eeprom_pkg::ST_RDOUT && opcode == eeprom_pkg::OP_ARRAY_READ
      |=> array_rd_req && array_rd_addr == 14'($past(array_rd_addr) + 1'b1);
  endproperty
  a_read_inc: assert property (p_read_inc) else $error("address not stepped");
  property p_oe_off;
    cs_rise |=> state == eeprom_pkg::ST_IDLE && !miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven deselected");
  property p_prot;
    boundary_ok && opcode == eeprom_pkg::OP_ARRAY_WRITE && prot_hit(bp, array_wr_addr)
      && !busy |=> !busy;
  endproperty
  a_prot: assert property (p_prot) else $error("protected write ran");

  property p_cov_status;
    byte_done && opcode == eeprom_pkg::OP_STATUS_READ && state == eeprom_pkg::ST_RDOUT;
  endproperty
  c_cov_status: cover property (p_cov_status);
  property p_cov_mem;
    start_mem;
  endproperty
  c_cov_mem: cover property (p_cov_mem);
  property p_cov_hw;
    hw_protect_mode && cs_rise;
  endproperty
  c_cov_hw: cover property (p_cov_hw);
endmodule : spi_eeprom_command_status
`default_nettype wire

// ### eeprom_pkg.sv
// Purpose: Shared constants and types of the serial EEPROM command block.
// Assumes: Opcodes arrive most significant bit first.
// Notes: Non-volatile status bits come up from a plain reset image.
`default_nettype none
package eeprom_pkg;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] OP_AUX_READ = 8'h83;
  localparam logic [7:0] OP_AUX_WRITE = 8'h82;
  localparam int SB_DISABLE = 7;
  localparam int SB_PROT_HI = 3;
  localparam int SB_PROT_LO = 2;
  localparam int ADDR_W = 14;
  localparam int SEL_SERIAL = 9;
  localparam int SEL_LOCK = 10;
  localparam logic [13:0] PROT_QUARTER = 14'h3000;
  localparam logic [13:0] PROT_HALF = 14'h2000;
  localparam logic [2:0] NV_RESET = 3'h0;
  localparam logic [2:0] UNUSED_BITS = 3'h0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [6:0] ONE_BYTE = 7'h01;
  localparam logic [6:0] NO_BYTES = 7'h00;
  localparam logic [6:0] MAX_BYTES = 7'h7f;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_OPCODE = 6'h02, ST_ADDR = 6'h04,
    ST_WDATA = 6'h08, ST_RDOUT = 6'h10, ST_WAIT = 6'h20
  } spi_state_t;
  typedef enum logic [1:0] {
    REG_ARRAY = 2'h0, REG_ID = 2'h1, REG_LOCK = 2'h2, REG_SERIAL = 2'h3
  } region_t;
  typedef enum logic [1:0] {
    WK_STATUS = 2'h0, WK_ARRAY = 2'h1, WK_AUX = 2'h2
  } write_kind_t;
endpackage : eeprom_pkg
`default_nettype wire

// ### spi_host_model.sv
// Purpose: Behavioural host controller that frames commands on the serial link.
// Assumes: Mode 0 timing, link clock period of 8 sys_clk cycles (32 ns).
// Notes: The link clock stands still low between frames.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input wire logic sys_clk,
  input wire logic miso,
  output logic sel_n,
  output logic sck,
  output logic mosi
);
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end

  task automatic begin_frame();
    @(posedge sys_clk);
    sel_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : begin_frame

  // Shifts the top nbits of tx out and samples the reply once the clock is high.
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nbits; i--) begin
      mosi <= tx[i];
      repeat (4) @(posedge sys_clk);
      sck <= 1'b1;
      @(negedge sys_clk);
      rx[i] = miso;
      repeat (4) @(posedge sys_clk);
      sck <= 1'b0;
    end
  endtask : xfer

  // Deselect rises four cycles after the last falling clock edge.
  task automatic end_frame();
    repeat (4) @(posedge sys_clk);
    sel_n <= 1'b1;
    mosi <= ~mosi;
    repeat (8) @(posedge sys_clk);
  endtask : end_frame
endmodule : spi_host_model
`default_nettype wire

// ### spi_eeprom_command_status_tb_top.sv
// Purpose: Self-checking bench for the serial EEPROM command and status block.
// Assumes: Array reads answer one cycle after the request; write side stalls.
// Notes: Write cycle length is shortened so a cycle still spans a status read.
`timescale 1ns/1ns
`default_nettype none
module spi_eeprom_command_status_tb_top;
  localparam int WCYC = 400;
  logic sys_clk, rst, wp_n, array_wr_ready, sel_n, sck, mosi, miso, miso_oe;
  logic array_rd_req, array_wr_valid;
  logic [13:0] array_rd_addr, array_wr_addr;
  logic [7:0] array_rd_data, array_wr_data, status_register, rx;
  logic [1:0] aux_region;
  int bad_count, checks;
  logic [7:0] wr_q[$];

  spi_eeprom_command_status #(.WRITE_CYCLES(WCYC)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .sel_n(sel_n), .sck(sck), .mosi(mosi), .wp_n(wp_n),
    .miso(miso), .miso_oe(miso_oe), .array_rd_addr(array_rd_addr),
    .array_rd_req(array_rd_req), .array_rd_data(array_rd_data),
    .array_wr_addr(array_wr_addr), .array_wr_data(array_wr_data),
    .array_wr_valid(array_wr_valid), .array_wr_ready(array_wr_ready),
    .aux_region(aux_region), .status_register(status_register));

  spi_host_model host_u (.sys_clk(sys_clk), .miso(miso), .sel_n(sel_n), .sck(sck),
    .mosi(mosi));

  function automatic logic [7:0] mem_at(input logic [13:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction : mem_at

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    array_wr_ready = 1'b0;
    array_rd_data = 8'h00;
  end

  always @(posedge sys_clk) begin
    array_wr_ready <= ~array_wr_ready;
    if (array_rd_req) begin
      array_rd_data <= mem_at(array_rd_addr);
    end
    if (array_wr_valid && array_wr_ready) begin
      wr_q.push_back(array_wr_data);
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic sb(input logic [7:0] b);
    host_u.xfer(b, 8, rx);
  endtask : sb

  task automatic cmd(input logic [7:0] op);
    host_u.begin_frame();
    sb(op);
    host_u.end_frame();
  endtask : cmd

  task automatic rd_status(input logic [7:0] exp);
    host_u.begin_frame();
    sb(8'h05);
    repeat (2) begin
      sb(8'h00);
      check(rx, exp);
    end
    host_u.end_frame();
  endtask : rd_status

  task automatic wr_status(input logic [7:0] v);
    host_u.begin_frame();
    sb(8'h01);
    sb(v);
    host_u.end_frame();
  endtask : wr_status

  task automatic arr_write(input logic [13:0] a, input int n, input logic [7:0] d0);
    wr_q.delete();
    host_u.begin_frame();
    sb(8'h02);
    sb({2'b11, a[13:8]});
    sb(a[7:0]);
    for (int i = 0; i < n; i++) begin
      sb(d0 + 8'(i));
    end
    host_u.end_frame();
  endtask : arr_write

  task automatic wait_idle();
    for (int i = 0; i < 1000 && status_register[0] !== 1'b0; i++) begin
      @(posedge sys_clk);
    end
  endtask : wait_idle

  task automatic t_end(input string s);
    $display("Test %s finished, mismatches so far %0d", s, bad_count);
  endtask : t_end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check(status_register, 8'h00);
    check({7'h00, miso_oe}, 8'h00);
    rd_status(8'h00);
    t_end("reset");
    cmd(8'h06);
    rd_status(8'h02);
    cmd(8'h04);
    rd_status(8'h00);
    host_u.begin_frame();
    sb(8'h06);
    host_u.xfer(8'h00, 3, rx);
    host_u.end_frame();
    rd_status(8'h00);
    host_u.begin_frame();
    sb(8'hff);
    sb(8'h06);
    host_u.end_frame();
    rd_status(8'h00);
    t_end("latch");
    wr_status(8'h8c);
    wait_idle();
    check(status_register, 8'h00);
    cmd(8'h06);
    wr_status(8'hff);
    rd_status(8'h03);
    wait_idle();
    check(status_register, 8'h8c);
    wp_n <= 1'b0;
    cmd(8'h06);
    wr_status(8'h00);
    wait_idle();
    check(status_register & 8'hfd, 8'h8c);
    wp_n <= 1'b1;
    cmd(8'h06);
    wr_status(8'h0c);
    wait_idle();
    check(status_register, 8'h0c);
    t_end("status write");
    cmd(8'h06);
    arr_write(14'h0010, 1, 8'h11);
    wait_idle();
    check(8'(wr_q.size()), 8'h00);
    cmd(8'h06);
    wr_status(8'h04);
    wait_idle();
    cmd(8'h06);
    arr_write(14'h3000, 1, 8'h22);
    wait_idle();
    check(8'(wr_q.size()), 8'h00);
    arr_write(14'h0010, 2, 8'ha0);
    wait_idle();
    check(8'(wr_q.size()), 8'h02);
    check(wr_q.size() > 1 ? wr_q[1] : 8'h00, 8'ha1);
    check(wr_q.size() > 0 ? wr_q[0] : 8'h00, 8'ha0);
    check(array_wr_addr[7:0], 8'h10);
    check(status_register, 8'h04);
    cmd(8'h06);
    arr_write(14'h0020, 9, 8'h30);
    wait_idle();
    check(8'(wr_q.size()), 8'h00);
    t_end("array write");
    host_u.begin_frame();
    sb(8'h03);
    sb(8'hff);
    sb(8'hfe);
    for (int k = 0; k < 3; k++) begin
      sb(8'h00);
      check(rx, mem_at(14'h3ffe + 14'(k)));
    end
    host_u.end_frame();
    check({7'h00, miso_oe}, 8'h00);
    check({2'h0, array_rd_addr[13:8]}, 8'h00);
    cmd(8'h06);
    arr_write(14'h0040, 1, 8'h44);
    host_u.begin_frame();
    sb(8'h03);
    sb(8'h00);
    sb(8'h00);
    check({7'h00, miso_oe}, 8'h00);
    host_u.end_frame();
    wait_idle();
    t_end("array read");
    for (int k = 0; k < 3; k++) begin
      host_u.begin_frame();
      sb(8'h83);
      sb(k == 0 ? 8'h02 : k == 1 ? 8'h04 : 8'h00);
      sb(8'h05);
      repeat (4) @(posedge sys_clk);
      check({6'h00, aux_region}, 8'(3 - k));
      host_u.end_frame();
    end
    cmd(8'h06);
    host_u.begin_frame();
    sb(8'h82);
    sb(8'h00);
    sb(8'h00);
    sb(8'h11);
    host_u.end_frame();
    check(status_register, 8'h07);
    wait_idle();
    check(status_register, 8'h04);
    t_end("aux decode");
    report_and_stop();
  end
endmodule : spi_eeprom_command_status_tb_top
`default_nettype wire
